// file: src/lpc_defs.vh
// constants for the log-pcm compander: code layout, law and direction codes
// assumes a single 100 MHz clock domain and an include by bare name
`ifndef LPC_DEFS_VH
`define LPC_DEFS_VH

`define LPC_W_WORD 16
`define LPC_W_CODE 8
`define LPC_CODE_SIGN 7
`define LPC_SEG_HI 6
`define LPC_SEG_LO 4
`define LPC_LVL_HI 3
`define LPC_LVL_LO 0
`define LPC_ALAW_XOR 8'h55
`define LPC_ULAW_XOR 8'h7F
`define LPC_ULAW_BIAS 14'h0021
`define LPC_ULAW_CLIP 14'h1FFF
`define LPC_ALAW_CLIP 13'h0FFF
`define LPC_ULAW_LIN_BIAS 16'h0084
`define LPC_ALAW_SEG_OFS 13'h0020
`define LPC_A_LSB 3
`define LPC_U_LSB 2
`define LPC_LAW_A 1'b1
`define LPC_LAW_U 1'b0
`define LPC_DIR_COMP 1'b0
`define LPC_DIR_EXP 1'b1
`define LPC_FIFO_DEPTH 16
`define LPC_FIFO_AW 4

`endif

// file: src/lpc_fifo.v
// synchronous fifo with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module lpc_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
)
(
    input wire i_clk_sys,
    input wire i_rstn,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    assign o_in_ready = (count_r != DEPTH[AW:0]);
    assign o_out_valid = (count_r != {(AW+1){1'b0}});
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;
    // data comes straight from the array; entries are written on the same edge that valid rises
    assign o_out_data = mem[rd_ptr_r];

    // ------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------
    always @(posedge i_clk_sys)
    begin
        if (push)
        begin
            mem[wr_ptr_r] <= i_in_data;
        end
    end

    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop)
            begin
                rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop)
            begin
                count_r <= count_r + {{AW{1'b0}}, 1'b1};
            end
            else if (pop && !push)
            begin
                count_r <= count_r - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// file: src/lpc_compander.v
// log-pcm compander: one converted sample per accepted input, results queued in a fifo
// assumes upstream and downstream logic on i_clk_sys; law and direction held static
`include "lpc_defs.vh"
`timescale 1ns/1ps
module lpc_compander
(
    input wire i_clk_sys,
    input wire i_rstn,
    input wire i_law_a,
    input wire i_dir_expand,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [15:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [15:0] o_out_data
);
    reg [15:0] conv_r;
    reg conv_vld_r;
    reg [7:0] enc_code;
    reg [15:0] dec_word;
    reg [15:0] conv_nxt;
    wire fifo_in_ready;
    wire take;

    // ------------------------------------------------------------
    // input folding
    // ------------------------------------------------------------
    // one's complement fold keeps the negative full scale in range
    wire in_neg;
    wire [12:0] a_fold;
    wire [13:0] u_fold;
    wire [12:0] a_mag;
    reg [13:0] u_mag;
    assign in_neg = i_in_data[`LPC_W_WORD-1];
    // bits below the law's width are never looked at
    assign a_fold = in_neg ? ~i_in_data[`LPC_W_WORD-1:`LPC_A_LSB] :
        i_in_data[`LPC_W_WORD-1:`LPC_A_LSB];
    assign u_fold = in_neg ? ~i_in_data[`LPC_W_WORD-1:`LPC_U_LSB] :
        i_in_data[`LPC_W_WORD-1:`LPC_U_LSB];
    assign a_mag = a_fold & `LPC_ALAW_CLIP;

    // clip before biasing so the sum cannot wrap
    always @*
    begin
        u_mag = u_fold + `LPC_ULAW_BIAS;
        if (u_fold > (`LPC_ULAW_CLIP - `LPC_ULAW_BIAS))
        begin
            u_mag = `LPC_ULAW_CLIP;
        end
    end

    // ------------------------------------------------------------
    // segment classification
    // ------------------------------------------------------------
    wire [7:1] a_hit;
    wire [7:1] u_hit;
    reg [2:0] a_seg;
    reg [2:0] u_seg;
    genvar g;
    generate
        for (g = 1; g < 8; g = g + 1)
        begin : g_seg
            assign a_hit[g] = a_mag[g + 4];
            assign u_hit[g] = u_mag[g + 5];
        end
    endgenerate

    always @*
    begin
        casez (a_hit)
            7'b1??????:
            begin
                a_seg = 3'h7;
            end
            7'b01?????:
            begin
                a_seg = 3'h6;
            end
            7'b001????:
            begin
                a_seg = 3'h5;
            end
            7'b0001???:
            begin
                a_seg = 3'h4;
            end
            7'b00001??:
            begin
                a_seg = 3'h3;
            end
            7'b000001?:
            begin
                a_seg = 3'h2;
            end
            7'b0000001:
            begin
                a_seg = 3'h1;
            end
            default:
            begin
                a_seg = 3'h0;
            end
        endcase
    end

    always @*
    begin
        casez (u_hit)
            7'b1??????:
            begin
                u_seg = 3'h7;
            end
            7'b01?????:
            begin
                u_seg = 3'h6;
            end
            7'b001????:
            begin
                u_seg = 3'h5;
            end
            7'b0001???:
            begin
                u_seg = 3'h4;
            end
            7'b00001??:
            begin
                u_seg = 3'h3;
            end
            7'b000001?:
            begin
                u_seg = 3'h2;
            end
            7'b0000001:
            begin
                u_seg = 3'h1;
            end
            default:
            begin
                u_seg = 3'h0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // in-segment quantisation and code assembly
    // ------------------------------------------------------------
    // segments 0 and 1 share a step of two, then it doubles
    reg [3:0] a_lvl;
    wire [13:0] u_shift;
    wire [3:0] u_lvl;
    wire [7:0] a_raw;
    wire [7:0] u_raw;
    always @*
    begin
        case (a_seg)
            3'h0:
            begin
                a_lvl = a_mag[4:1];
            end
            3'h1:
            begin
                a_lvl = a_mag[4:1];
            end
            3'h2:
            begin
                a_lvl = a_mag[5:2];
            end
            3'h3:
            begin
                a_lvl = a_mag[6:3];
            end
            3'h4:
            begin
                a_lvl = a_mag[7:4];
            end
            3'h5:
            begin
                a_lvl = a_mag[8:5];
            end
            3'h6:
            begin
                a_lvl = a_mag[9:6];
            end
            default:
            begin
                a_lvl = a_mag[10:7];
            end
        endcase
    end

    // shift amount widened so segment 7 does not wrap to zero
    assign u_shift = u_mag >> ({1'b0, u_seg} + 4'h1);
    assign u_lvl = u_shift[3:0];
    assign a_raw = {~in_neg, a_seg, a_lvl};
    assign u_raw = {~in_neg, u_seg, u_lvl};

    always @*
    begin
        if (i_law_a == `LPC_LAW_A)
        begin
            enc_code = a_raw ^ `LPC_ALAW_XOR;
        end
        else
        begin
            enc_code = u_raw ^ `LPC_ULAW_XOR;
        end
    end

    // ------------------------------------------------------------
    // expander
    // ------------------------------------------------------------
    wire [7:0] code_mask;
    wire [7:0] code;
    wire code_pos;
    wire [2:0] ex;
    wire [3:0] man;
    wire [12:0] a_base;
    wire [12:0] a_lin;
    wire [15:0] a_word;
    wire [15:0] u_base;
    wire [15:0] u_word;
    // low 8 bits hold the code, upper bits are ignored
    assign code_mask = (i_law_a == `LPC_LAW_A) ? `LPC_ALAW_XOR : `LPC_ULAW_XOR;
    assign code = i_in_data[`LPC_W_CODE-1:0] ^ code_mask;
    assign code_pos = code[`LPC_CODE_SIGN];
    assign ex = code[`LPC_SEG_HI:`LPC_SEG_LO];
    assign man = code[`LPC_LVL_HI:`LPC_LVL_LO];
    // mid-step levels, so a level fed back in maps to its own code
    assign a_base = {8'h00, man, 1'b1};
    assign a_lin = (ex == 3'h0) ? a_base : ((a_base + `LPC_ALAW_SEG_OFS) << (ex - 3'h1));
    assign a_word = {a_lin, 3'h0};
    assign u_base = {9'h000, man, 3'h0} + `LPC_ULAW_LIN_BIAS;
    assign u_word = (u_base << ex) - `LPC_ULAW_LIN_BIAS;

    // one's complement sign mirrors the input fold, so round trips are exact
    always @*
    begin
        if (i_law_a == `LPC_LAW_A)
        begin
            dec_word = code_pos ? a_word : ~a_word;
        end
        else
        begin
            dec_word = code_pos ? u_word : ~u_word;
        end
    end

    // ------------------------------------------------------------
    // single pipeline stage; holds only the sample in flight
    // ------------------------------------------------------------
    // stage stalls when the fifo is full, so back-pressure reaches the source
    assign take = i_in_valid & o_in_ready;
    assign o_in_ready = ~conv_vld_r | fifo_in_ready;

    always @*
    begin
        conv_nxt = (i_dir_expand == `LPC_DIR_EXP) ? dec_word : {8'h00, enc_code};
    end

    always @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            conv_r <= 16'h0000;
            conv_vld_r <= 1'b0;
        end
        else
        begin
            if (take)
            begin
                conv_r <= conv_nxt;
                conv_vld_r <= 1'b1;
            end
            else if (fifo_in_ready)
            begin
                conv_vld_r <= 1'b0;
            end
        end
    end

    lpc_fifo #(
        .WIDTH(`LPC_W_WORD),
        .DEPTH(`LPC_FIFO_DEPTH),
        .AW(`LPC_FIFO_AW)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_in_valid(conv_vld_r),
        .o_in_ready(fifo_in_ready),
        .i_in_data(conv_r),
        .o_out_valid(o_out_valid),
        .i_out_ready(i_out_ready),
        .o_out_data(o_out_data)
    );
endmodule

// file: verification/lpc_sink.sv
// downstream sample sink; the bench reads its queue of received words
// assumes the compander's clock and reset
`timescale 1ns/1ps
module lpc_sink
(
    input wire i_clk_sys,
    input wire i_rstn,
    input wire i_stall,
    input wire i_slow,
    input wire i_valid,
    input wire [15:0] i_data,
    output logic o_ready
);
    logic [15:0] got[$];
    // slow mode drops ready every other cycle so the fifo backs up a little
    always @(posedge i_clk_sys or negedge i_rstn)
        if (!i_rstn)
            o_ready <= 1'b0;
        else
        begin
            if (i_valid && o_ready)
                got.push_back(i_data);
            o_ready <= !i_stall && !(i_slow && o_ready);
        end
endmodule

// file: verification/lpc_compander_properties.sv
// stream-port checker, bound into every compander instance
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module lpc_compander_properties
(
    input wire i_clk_sys,
    input wire i_rstn,
    input wire i_law_a,
    input wire i_dir_expand,
    input wire i_in_valid,
    input wire o_in_ready,
    input wire [15:0] i_in_data,
    input wire o_out_valid,
    input wire i_out_ready,
    input wire [15:0] o_out_data
);
    // words in flight, stage plus fifo; 17 means no room anywhere
    logic [5:0] occ_r;
    wire take = i_in_valid & o_in_ready;
    wire pop = o_out_valid & i_out_ready;
    always @(posedge i_clk_sys or negedge i_rstn)
        if (!i_rstn)
            occ_r <= 6'h00;
        else
            occ_r <= occ_r + {5'h00, take} - {5'h00, pop};
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    sequence s_lone_take; take && !o_out_valid && !$past(take); endsequence
    sequence s_answer; !o_out_valid ##1 o_out_valid; endsequence
    reset_idle_a: assert property ($rose(i_rstn) |-> !o_out_valid && o_in_ready)
        else $error("busy after reset");
    out_hold_a: assert property (o_out_valid && !i_out_ready |=>
        o_out_valid && $stable(o_out_data)) else $error("output not held");
    answer_time_a: assert property (s_lone_take |=> s_answer)
        else $error("late answer");
    no_spurious_a: assert property ($rose(o_out_valid) |-> $past(take, 2))
        else $error("word without input");
    code_justify_a: assert property (o_out_valid && !i_dir_expand |->
        o_out_data[15:8] == 8'h00) else $error("code not right-justified");
    lin_justify_a: assert property (o_out_valid && i_dir_expand && !o_out_data[15] |->
        (o_out_data & (i_law_a ? 16'h0007 : 16'h0003)) == 16'h0000) else $error("low bits set");
    full_level_a: assert property (!o_in_ready |-> occ_r == 6'h11)
        else $error("refused with room");
    out_pairing_a: assert property (o_out_valid |-> occ_r != 6'h00)
        else $error("extra word");
endmodule
bind lpc_compander lpc_compander_properties lpc_compander_properties_i (.i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn), .i_law_a(i_law_a), .i_dir_expand(i_dir_expand), .i_in_valid(i_in_valid),
    .o_in_ready(o_in_ready), .i_in_data(i_in_data), .o_out_valid(o_out_valid),
    .i_out_ready(i_out_ready), .o_out_data(o_out_data));

// file: verification/lpc_compander_test.sv
// bench: round trips of every code, full-scale points, fifo fill and drain
// assumes the compander sources and the sink model are compiled first
`timescale 1ns/1ps
module lpc_compander_test;
    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic i_law_a = 1'b0;
    logic i_dir_expand = 1'b0;
    logic i_in_valid = 1'b0;
    logic [15:0] i_in_data = 16'h0000;
    logic stall = 1'b0;
    logic slow = 1'b0;
    wire o_in_ready;
    wire o_out_valid;
    wire i_out_ready;
    wire [15:0] o_out_data;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [15:0] lin_tab[256];
    initial forever #5 i_clk_sys = ~i_clk_sys;
    lpc_compander lpc_compander_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_law_a(i_law_a),
        .i_dir_expand(i_dir_expand), .i_in_valid(i_in_valid), .o_in_ready(o_in_ready),
        .i_in_data(i_in_data), .o_out_valid(o_out_valid), .i_out_ready(i_out_ready),
        .o_out_data(o_out_data));
    lpc_sink lpc_sink_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_stall(stall),
        .i_slow(slow), .i_valid(o_out_valid), .i_data(o_out_data), .o_ready(i_out_ready));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [15:0] d);
        i_in_valid <= 1'b1;
        i_in_data <= d;
        @(negedge i_clk_sys);
        while (!o_in_ready)
            @(negedge i_clk_sys);
        @(posedge i_clk_sys);
    endtask
    // waits for n words, bounded, since a lost word would otherwise hang here
    task automatic collect(input int n);
        for (int k = 0; k < 200 && lpc_sink_i.got.size() < n; k++)
            @(posedge i_clk_sys);
    endtask
    task automatic run(input logic [15:0] d[$]);
        lpc_sink_i.got.delete();
        foreach (d[j])
            send(d[j]);
        i_in_valid <= 1'b0;
        collect(d.size());
    endtask
    task automatic one(input logic law, input logic dir, input logic [15:0] d, input logic [15:0] e);
        @(posedge i_clk_sys);
        i_law_a <= law;
        i_dir_expand <= dir;
        run('{d});
        cmp(lpc_sink_i.got[0], e);
    endtask
    // low ignored bits set on the way back must not move the code
    task automatic t_round(input logic law);
        logic [15:0] d[$];
        i_law_a <= law;
        i_dir_expand <= 1'b1;
        for (int j = 0; j < 256; j++)
            d.push_back(16'(j));
        run(d);
        for (int j = 0; j < 256; j++)
        begin
            lin_tab[j] = lpc_sink_i.got[j];
            cmp({15'h0000, lin_tab[j][15]}, {15'h0000, ~d[j][7]});
            d[j] = lin_tab[j] | (law ? 16'h0007 : 16'h0003);
        end
        i_dir_expand <= 1'b0;
        run(d);
        for (int j = 0; j < 256; j++)
            cmp(lpc_sink_i.got[j], 16'(j));
    endtask
    task automatic t_fill;
        i_law_a <= 1'b1;
        stall <= 1'b1;
        lpc_sink_i.got.delete();
        for (int j = 0; j < 17; j++)
            send(lin_tab[j + 100]);
        i_in_valid <= 1'b0;
        repeat (3) @(negedge i_clk_sys);
        cmp({14'h0000, o_in_ready, o_out_valid}, 16'h0001);
        @(posedge i_clk_sys);
        stall <= 1'b0;
        collect(17);
        @(negedge i_clk_sys);
        for (int j = 0; j < 17; j++)
            cmp(lpc_sink_i.got[j], 16'(j + 100));
        cmp({14'h0000, o_in_ready, o_out_valid}, 16'h0002);
    endtask
    task automatic end_sim;
        $display("mismatches %0d, compares %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #300000;
        n_mismatch++;
        end_sim();
    end
    initial
    begin
        repeat (3) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        @(posedge i_clk_sys);
        slow <= 1'b1;
        t_round(1'b0);
        t_round(1'b1);
        slow <= 1'b0;
        t_fill();
        one(1'b1, 1'b0, 16'h7FFF, 16'h00AA);
        one(1'b1, 1'b0, 16'h8000, 16'h002A);
        one(1'b0, 1'b0, 16'h7FFF, 16'h0080);
        one(1'b0, 1'b0, 16'h8000, 16'h0000);
        one(1'b1, 1'b1, 16'h00D5, 16'h0008);
        one(1'b0, 1'b1, 16'h0080, 16'h7D7C);
        end_sim();
    end
endmodule
